// ### pkg/lro_pkg.sv
`default_nettype none
package lro_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;
  // Control field layout, low bits of the control word
  typedef struct packed {
    logic e3_rate;
    logic single_rail;
    logic fall_edge;
    logic shared_clk;
  } lro_ctrl_s;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Event layout shared by the sticky status and the mask
  typedef struct packed {
    logic cv;
    logic loss_of_lock;
    logic loss_of_signal;
  } lro_evt_s;
  localparam int EVT_W = 3;
  localparam logic [2:0] EVT_RST = 3'h0;
  // Live state word: bit 0 signal lost, bit 1 lock lost, bit 2 reference selected, bit 3 host mode
  localparam int STATE_W = 4;
  // Loss of signal: consecutive bit periods without a pulse
  localparam logic [7:0] LOS_ZEROS_E3 = 8'h20;
  localparam logic [7:0] LOS_ZEROS_DS3 = 8'hAF;
  // Loss of lock: window in reference edges and allowed deviation (0.5 percent of it)
  localparam logic [9:0] LOL_WINDOW = 10'h3E8;
  localparam logic [10:0] LOL_TOL = 11'h005;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Source of the receive clock outputs
  typedef enum logic [1:0] {
    SRC_REC = 2'b01,
    SRC_REF = 2'b10
  } lro_src_e;
endpackage
`default_nettype wire

// ### logic/lro_sync.sv
`default_nettype none
module lro_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_ff <= '0;
      q <= '0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ### logic/lro_rx_output.sv
// Notes on behaviour
// - Loss-of-signal flag output goes high while loss of signal is detected.
// - Loss-of-signal threshold differs between E3 and DS3/STS-1 rate.
// - While lock is lost, receive clock outputs come from the reference clock.
// - Host mode: shared pin defaults to code violation; control bit makes it clock.
// - Hardware mode: shared pin always carries the same clock as the first recovered clock pin.
// - First recovered clock pin carries the recovered clock, or the reference clock while lock is lost.
// - Rail outputs update on the rising edge of the receive clock by default.
// - Host mode may select falling-edge update of the rail outputs.
// - Falling-edge update also applies when the shared pin acts as clock.
// - Lock lost when recovered clock deviates from reference by over 0.5 percent.
// - Code violation flag is high for exactly one bit period per violation.
// - Single-rail mode: negative rail inactive, binary data on positive rail.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module lro_rx_output (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Recovered line signal and reference clock
  input wire logic LINE_CLK_IN,
  input wire logic REFERENCE_CLOCK_IN,
  input wire logic LINE_POS_IN,
  input wire logic LINE_NEG_IN,
  input wire logic LINE_CV_IN,
  // Straps
  input wire logic HOST_MODE_IN,
  input wire logic HW_E3_SEL_IN,
  input wire logic HW_DUAL_RAIL_IN,
  // Terminal side outputs
  output logic FIRST_RECOVERED_CLOCK,
  output logic SHARED_CLK2_CV_OUT,
  output logic POSITIVE_RAIL_OUT,
  output logic NEGATIVE_RAIL_OUT,
  output logic LOSS_OF_SIGNAL_FLAG,
  output logic LOSS_OF_LOCK,
  output logic IRQ
);
  logic [7:0] in_s;
  logic rec_s, ref_s, pos_s, neg_s, cv_s, host_s, hw_e3_s, hw_dual_s;
  logic rec_prev_ff, ref_prev_ff, rec_tick, ref_tick;
  localparam int CTRL_W_L = lro_pkg::CTRL_W;
  logic [CTRL_W_L-1:0] ctrl_ff;
  lro_pkg::lro_ctrl_s ctrl;
  logic e3_mode, single_mode, fall_mode, shared_clk;
  lro_pkg::lro_evt_s int_stat_ff, int_mask_ff, evt;
  logic aw_got_ff, w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic do_write;
  logic [7:0] los_cnt_ff, los_thr;
  logic los_ff, los_prev_ff;
  logic [9:0] win_cnt_ff;
  logic [10:0] rec_cnt_ff, lol_diff;
  logic lol_ff, lol_prev_ff;
  lro_pkg::lro_src_e src_ff;
  logic park_ff, cur_s;
  logic clk_out_ff, clk_prev_ff, out_rise, out_fall, upd;
  logic pos_hold_ff, neg_hold_ff, cv_hold_ff;
  logic pos_ff, neg_ff, lcv_ff;

  // Every line and strap input passes two flip-flops before use
  lro_sync #(
    .W(8)
  ) u_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .d({LINE_CLK_IN, REFERENCE_CLOCK_IN, LINE_POS_IN, LINE_NEG_IN, LINE_CV_IN,
        HOST_MODE_IN, HW_E3_SEL_IN, HW_DUAL_RAIL_IN}),
    .q(in_s)
  );
  assign {rec_s, ref_s, pos_s, neg_s, cv_s, host_s, hw_e3_s, hw_dual_s} = in_s;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      rec_prev_ff <= 1'b0;
      ref_prev_ff <= 1'b0;
    end
    else
    begin
      rec_prev_ff <= rec_s;
      ref_prev_ff <= ref_s;
    end
  end
  assign rec_tick = rec_s && !rec_prev_ff;
  assign ref_tick = ref_s && !ref_prev_ff;

  // Mode: registers in host mode; in hardware mode rate and rails from strap pins, rising-edge update and shared clock fixed
  assign ctrl = lro_pkg::lro_ctrl_s'(ctrl_ff);
  assign e3_mode = host_s ? ctrl.e3_rate : hw_e3_s;
  assign single_mode = host_s ? ctrl.single_rail : !hw_dual_s;
  assign fall_mode = host_s && ctrl.fall_edge;
  assign shared_clk = !host_s || ctrl.shared_clk;

  // AXI write path: address and data taken in either order
  assign AWREADY = !aw_got_ff && !BVALID;
  assign WREADY = !w_got_ff && !BVALID;
  assign do_write = aw_got_ff && w_got_ff && !BVALID;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= lro_pkg::RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_got_ff <= 1'b1;
        w_data_ff <= WDATA;
        w_strb_ff <= WSTRB;
      end
      if (do_write)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        BVALID <= 1'b1;
        case (aw_addr_ff)
          lro_pkg::OFS_CTRL, lro_pkg::OFS_STATE, lro_pkg::OFS_INT_STAT, lro_pkg::OFS_INT_MASK:
            BRESP <= lro_pkg::RESP_OKAY;
          default:
            BRESP <= lro_pkg::RESP_SLVERR;
        endcase
      end
      else if (BVALID && BREADY)
      begin
        BVALID <= 1'b0;
      end
    end
  end

  // Control and mask registers, low byte lane only
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      ctrl_ff <= lro_pkg::CTRL_RST;
      int_mask_ff <= lro_pkg::EVT_RST;
    end
    else if (do_write && w_strb_ff[0])
    begin
      if (aw_addr_ff == lro_pkg::OFS_CTRL)
        ctrl_ff <= w_data_ff[CTRL_W_L-1:0];
      if (aw_addr_ff == lro_pkg::OFS_INT_MASK)
        int_mask_ff <= w_data_ff[lro_pkg::EVT_W-1:0];
    end
  end

  // Sticky events; a new event wins over a write-one-to-clear
  assign evt = '{cv: upd && cv_hold_ff, loss_of_lock: lol_ff && !lol_prev_ff, loss_of_signal: los_ff && !los_prev_ff};
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      int_stat_ff <= lro_pkg::EVT_RST;
    else if (do_write && w_strb_ff[0] && aw_addr_ff == lro_pkg::OFS_INT_STAT)
      int_stat_ff <= (int_stat_ff & ~w_data_ff[lro_pkg::EVT_W-1:0]) | evt;
    else
      int_stat_ff <= int_stat_ff | evt;
  end
  assign IRQ = |(int_stat_ff & int_mask_ff);

  // AXI read path, one cycle to the answer
  assign ARREADY = !RVALID;
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= lro_pkg::RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      RVALID <= 1'b1;
      RRESP <= lro_pkg::RESP_OKAY;
      RDATA <= 32'h0000_0000;
      case (ARADDR)
        lro_pkg::OFS_CTRL:
          RDATA[CTRL_W_L-1:0] <= ctrl_ff;
        lro_pkg::OFS_STATE:
          RDATA[lro_pkg::STATE_W-1:0] <= {host_s, src_ff == lro_pkg::SRC_REF, lol_ff, los_ff};
        lro_pkg::OFS_INT_STAT:
          RDATA[lro_pkg::EVT_W-1:0] <= int_stat_ff;
        lro_pkg::OFS_INT_MASK:
          RDATA[lro_pkg::EVT_W-1:0] <= int_mask_ff;
        default:
          RRESP <= lro_pkg::RESP_SLVERR;
      endcase
    end
    else if (RVALID && RREADY)
    begin
      RVALID <= 1'b0;
    end
  end

  // Loss of signal: run of bit periods without a pulse
  assign los_thr = e3_mode ? lro_pkg::LOS_ZEROS_E3 : lro_pkg::LOS_ZEROS_DS3;
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      los_cnt_ff <= 8'h00;
      los_ff <= 1'b0;
      los_prev_ff <= 1'b0;
    end
    else
    begin
      los_prev_ff <= los_ff;
      if (rec_tick)
      begin
        if (pos_s || neg_s)
        begin
          los_cnt_ff <= 8'h00;
          los_ff <= 1'b0;
        end
        else if (los_cnt_ff >= los_thr - 8'h01)
        begin
          los_ff <= 1'b1;
        end
        else
        begin
          los_cnt_ff <= los_cnt_ff + 8'h01;
        end
      end
    end
  end
  assign LOSS_OF_SIGNAL_FLAG = los_ff;

  // Loss of lock: recovered edges counted over a window of reference edges
  assign lol_diff = (rec_cnt_ff > {1'b0, lro_pkg::LOL_WINDOW}) ?
                    rec_cnt_ff - {1'b0, lro_pkg::LOL_WINDOW} : {1'b0, lro_pkg::LOL_WINDOW} - rec_cnt_ff;
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      win_cnt_ff <= 10'h000;
      rec_cnt_ff <= 11'h000;
      lol_ff <= 1'b0;
      lol_prev_ff <= 1'b0;
    end
    else
    begin
      lol_prev_ff <= lol_ff;
      if (ref_tick && win_cnt_ff == lro_pkg::LOL_WINDOW - 10'h001)
      begin
        win_cnt_ff <= 10'h000;
        rec_cnt_ff <= {10'h000, rec_tick};
        lol_ff <= lol_diff > lro_pkg::LOL_TOL;
      end
      else
      begin
        if (ref_tick)
          win_cnt_ff <= win_cnt_ff + 10'h001;
        if (rec_tick && rec_cnt_ff != 11'h7FF)
          rec_cnt_ff <= rec_cnt_ff + 11'h001;
      end
    end
  end
  assign LOSS_OF_LOCK = lol_ff;

  // Clock source select: old source left while it and the output are low,
  // then the output is parked low until the new source is low too
  assign cur_s = (src_ff == lro_pkg::SRC_REF) ? ref_s : rec_s;
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      src_ff <= lro_pkg::SRC_REC;
      park_ff <= 1'b0;
    end
    else if (park_ff)
    begin
      if (!cur_s)
        park_ff <= 1'b0;
    end
    else
      case (src_ff)
        lro_pkg::SRC_REC:
          if (lol_ff && !clk_out_ff && !rec_s)
          begin
            src_ff <= lro_pkg::SRC_REF;
            park_ff <= 1'b1;
          end
        lro_pkg::SRC_REF:
          if (!lol_ff && !clk_out_ff && !ref_s)
          begin
            src_ff <= lro_pkg::SRC_REC;
            park_ff <= 1'b1;
          end
        default:
          src_ff <= lro_pkg::SRC_REC;
      endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      clk_out_ff <= 1'b0;
      clk_prev_ff <= 1'b0;
    end
    else
    begin
      clk_out_ff <= park_ff ? 1'b0 : cur_s;
      clk_prev_ff <= clk_out_ff;
    end
  end
  assign out_rise = clk_out_ff && !clk_prev_ff;
  assign out_fall = !clk_out_ff && clk_prev_ff;
  assign upd = fall_mode ? out_fall : out_rise;
  assign FIRST_RECOVERED_CLOCK = clk_out_ff;

  // Bit captured on the recovered clock, presented on the output clock edge
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      pos_hold_ff <= 1'b0;
      neg_hold_ff <= 1'b0;
      cv_hold_ff <= 1'b0;
    end
    else if (rec_tick)
    begin
      pos_hold_ff <= pos_s;
      neg_hold_ff <= neg_s;
      cv_hold_ff <= cv_s;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      pos_ff <= 1'b0;
      neg_ff <= 1'b0;
      lcv_ff <= 1'b0;
    end
    else if (upd)
    begin
      pos_ff <= single_mode ? (pos_hold_ff || neg_hold_ff) : pos_hold_ff;
      neg_ff <= single_mode ? 1'b0 : neg_hold_ff;
      lcv_ff <= cv_hold_ff;
    end
  end
  assign POSITIVE_RAIL_OUT = pos_ff;
  assign NEGATIVE_RAIL_OUT = neg_ff;
  assign SHARED_CLK2_CV_OUT = shared_clk ? clk_out_ff : lcv_ff;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_lock_lost;
    !lol_prev_ff ##1 lol_ff;
  endsequence
  sequence s_ref_taken;
    ##[1:64] (src_ff == lro_pkg::SRC_REF);
  endsequence

  chk_los_declare: assert property (rec_tick && !pos_s && !neg_s && los_cnt_ff == los_thr - 8'h01
    |=> LOSS_OF_SIGNAL_FLAG)
    else $error("loss of signal not declared at threshold");
  chk_los_rate: assert property ($rose(los_ff) |-> $past(los_cnt_ff) == (e3_mode ? 8'h1F : 8'hAE))
    else $error("loss of signal threshold does not match rate");
  chk_lol_ref_src: assert property (s_lock_lost |-> s_ref_taken or (##[1:64] !lol_ff))
    else $error("reference clock not selected after lock loss");
  chk_shared_lcv: assert property (host_s && !ctrl.shared_clk |-> SHARED_CLK2_CV_OUT == lcv_ff)
    else $error("shared pin not carrying code violation");
  chk_shared_hw_clk: assert property (!host_s |-> SHARED_CLK2_CV_OUT == FIRST_RECOVERED_CLOCK)
    else $error("shared pin not carrying clock in hardware mode");
  chk_clk1_follows: assert property ($past(src_ff) == lro_pkg::SRC_REC && !$past(park_ff)
    |-> FIRST_RECOVERED_CLOCK == $past(rec_s))
    else $error("first clock not following recovered clock");
  chk_rail_rise: assert property (!$past(fall_mode) && $changed(pos_ff) |-> $past(out_rise))
    else $error("rail changed away from rising edge");
  chk_rail_fall: assert property ($past(fall_mode) && !ctrl.shared_clk && $changed(neg_ff)
    |-> $past(out_fall))
    else $error("rail changed away from falling edge");
  chk_rail_fall_clk2: assert property ($past(fall_mode) && ctrl.shared_clk && $changed(pos_ff)
    |-> $past(out_fall))
    else $error("rail changed away from falling edge of clock two");
  chk_lol_tolerance: assert property (ref_tick && win_cnt_ff == 10'h3E7 && lol_diff > 11'h005 |=> lol_ff)
    else $error("loss of lock not declared beyond tolerance");
  chk_lcv_one_bit: assert property ($changed(lcv_ff) |-> $past(upd))
    else $error("code violation flag changed between bit edges");
  chk_single_neg_low: assert property (single_mode && upd |=> !NEGATIVE_RAIL_OUT)
    else $error("negative rail active in single rail mode");
  chk_no_runt: assert property ($changed(src_ff) |-> !$past(clk_out_ff) && !clk_out_ff)
    else $error("clock source switched while output high");
endmodule
`default_nettype wire

// ### sim/lro_line_model.sv
`default_nettype none
module lro_line_model (
  // Bench control
  input wire logic run,
  input wire logic [1:0] pat,
  input wire logic [9:0] ref_half,
  // Clocks and data toward the block
  output logic line_clk,
  output logic ref_clk,
  output logic pos,
  output logic neg,
  output logic cv
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_bit;
  // Recovered clock rests low while stopped; the data lines keep changing then
  initial
  begin
    line_clk = 1'b0;
    pos = 1'b0;
    neg = 1'b0;
    cv = 1'b0;
    n_bit = 0;
    #23;
    forever
    begin
      #400;
      line_clk = run & ~line_clk;
      if (!line_clk)
      begin
        n_bit++;
        pos = (pat != 2'h1) && n_bit[0];
        neg = (pat != 2'h1) && !n_bit[0];
        cv = (pat == 2'h2) && (n_bit[2:0] == 3'h0);
      end
    end
  end
  // Line-rate reference, trimmed by the bench to probe the lock tolerance
  initial
  begin
    ref_clk = 1'b0;
    #171;
    forever
    begin
      #(ref_half);
      ref_clk = ~ref_clk;
    end
  end
endmodule
`default_nettype wire

// ### sim/lro_rx_output_tb.sv
`default_nettype none
module lro_rx_output_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic host = 1'b1;
  logic hw_e3 = 1'b0;
  logic hw_dual = 1'b1;
  logic run = 1'b1;
  logic [1:0] pat = 2'h0;
  logic [9:0] ref_half = 10'h190;
  logic fall_mode = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, line_clk, ref_in, lpos, lneg, code_violation_flag;
  logic frc, shr, positive_rail_out, negative_rail_out, loss_of_signal, loss_of_lock, irq, frc_d1, frc_d2, shr_d1;
  logic [1:0] bresp, rresp, rails_d1;
  logic [31:0] rdata;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int frc_min = 99;
  int n_frc, n_shr, n_upd, bad_upd, n_neg, shr_run, shr_len, frc_run;

  lro_rx_output lro_rx_output_inst (
    .REF_CLK(clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .LINE_CLK_IN(line_clk),
    .REFERENCE_CLOCK_IN(ref_in), .LINE_POS_IN(lpos), .LINE_NEG_IN(lneg), .LINE_CV_IN(code_violation_flag),
    .HOST_MODE_IN(host), .HW_E3_SEL_IN(hw_e3), .HW_DUAL_RAIL_IN(hw_dual),
    .FIRST_RECOVERED_CLOCK(frc), .SHARED_CLK2_CV_OUT(shr), .POSITIVE_RAIL_OUT(positive_rail_out),
    .NEGATIVE_RAIL_OUT(negative_rail_out), .LOSS_OF_SIGNAL_FLAG(loss_of_signal), .LOSS_OF_LOCK(loss_of_lock), .IRQ(irq)
  );
  lro_line_model lro_line_model_inst (
    .run(run), .pat(pat), .ref_half(ref_half), .line_clk(line_clk), .ref_clk(ref_in),
    .pos(lpos), .neg(lneg), .cv(code_violation_flag)
  );

  always #50 clk = ~clk;

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Edge counts, placement of rail updates and pulse widths on the terminal side
  always @(posedge clk)
  begin
    frc_d1 <= frc;
    frc_d2 <= frc_d1;
    shr_d1 <= shr;
    rails_d1 <= {positive_rail_out, negative_rail_out};
    cyc++;
    if (frc && !frc_d1)
      n_frc++;
    if (shr && !shr_d1)
      n_shr++;
    if (negative_rail_out)
      n_neg++;
    if ({positive_rail_out, negative_rail_out} != rails_d1)
    begin
      n_upd++;
      if (!(((frc ^ fall_mode) && (frc_d1 == fall_mode)) || ((frc_d1 ^ fall_mode) && (frc_d2 == fall_mode))))
        bad_upd++;
    end
    shr_run <= shr ? shr_run + 1 : 0;
    if (!shr && shr_d1)
      shr_len <= shr_run;
    frc_run <= frc ? frc_run + 1 : 0;
    if (!frc && frc_d1 && rst_b && frc_run < frc_min)
      frc_min <= frc_run;
    if (cyc == 95000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk("write response", bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] msk, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    chk("read data", rdata & msk, ed);
    chk("read response", rresp, er);
  endtask

  // Lets a mode change settle, then counts over c cycles
  task automatic measure(input int c, input logic fm);
    repeat (16) @(posedge clk);
    @(negedge clk);
    fall_mode = fm;
    n_frc = 0;
    n_shr = 0;
    n_upd = 0;
    bad_upd = 0;
    n_neg = 0;
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    do_reset();
    rd(lro_pkg::OFS_CTRL, 32'h0, 32'hFFFFFFFF, lro_pkg::RESP_OKAY);
    rd(lro_pkg::OFS_INT_STAT, 32'h0, 32'hFFFFFFFF, lro_pkg::RESP_OKAY);
    rd(lro_pkg::OFS_INT_MASK, 32'h0, 32'hFFFFFFFF, lro_pkg::RESP_OKAY);
    rd(lro_pkg::OFS_STATE, 32'h8, 32'h8, lro_pkg::RESP_OKAY);
    rd(8'h10, 32'h0, 32'hFFFFFFFF, lro_pkg::RESP_SLVERR);
    wr(8'h10, 32'hFFFFFFFF, lro_pkg::RESP_SLVERR);
    rd(lro_pkg::OFS_CTRL, 32'h0, 32'hFFFFFFFF, lro_pkg::RESP_OKAY);
    measure(64, 1'b0);
    chk("first clock edges", n_frc, 8);
    chk("shared pin edges", n_shr, 0);
    chk("rail updates", n_upd, 8);
    chk("misplaced updates", bad_upd, 0);
    wr(lro_pkg::OFS_CTRL, 32'h1, lro_pkg::RESP_OKAY);
    measure(64, 1'b0);
    chk("shared clock edges", n_shr, 8);
    wr(lro_pkg::OFS_CTRL, 32'h2, lro_pkg::RESP_OKAY);
    measure(64, 1'b1);
    chk("falling clock one updates", n_upd, 8);
    chk("misplaced clock one updates", bad_upd, 0);
    wr(lro_pkg::OFS_CTRL, 32'h3, lro_pkg::RESP_OKAY);
    measure(64, 1'b1);
    chk("falling mode updates", n_upd, 8);
    chk("misplaced falling updates", bad_upd, 0);
    wr(lro_pkg::OFS_CTRL, 32'h4, lro_pkg::RESP_OKAY);
    measure(64, 1'b0);
    chk("negative rail high", n_neg, 0);
    chk("single rail changes", n_upd, 0);
    chk("positive rail", positive_rail_out, 1);
    wr(lro_pkg::OFS_CTRL, 32'h8, lro_pkg::RESP_OKAY);
    pat = 2'h1;
    wait_cyc(232);
    chk("short silence E3", loss_of_signal, 0);
    wait_cyc(56);
    chk("signal loss E3", loss_of_signal, 1);
    rd(lro_pkg::OFS_STATE, 32'h1, 32'h1, lro_pkg::RESP_OKAY);
    pat = 2'h0;
    wait_cyc(40);
    chk("signal back", loss_of_signal, 0);
    rd(lro_pkg::OFS_INT_STAT, 32'h1, 32'hFFFFFFFF, lro_pkg::RESP_OKAY);
    wr(lro_pkg::OFS_INT_MASK, 32'h1, lro_pkg::RESP_OKAY);
    wait_cyc(1);
    chk("interrupt raised", irq, 1);
    wr(lro_pkg::OFS_INT_STAT, 32'h1, lro_pkg::RESP_OKAY);
    wait_cyc(1);
    chk("interrupt cleared", irq, 0);
    wr(lro_pkg::OFS_CTRL, 32'h0, lro_pkg::RESP_OKAY);
    pat = 2'h1;
    wait_cyc(1360);
    chk("short silence DS3", loss_of_signal, 0);
    wait_cyc(80);
    chk("signal loss DS3", loss_of_signal, 1);
    pat = 2'h0;
    wait_cyc(40);
    wr(lro_pkg::OFS_INT_STAT, 32'h7, lro_pkg::RESP_OKAY);
    pat = 2'h2;
    measure(128, 1'b0);
    chk("violation pulse width", shr_len, 8);
    chk("violation pulses", n_shr, 2);
    pat = 2'h0;
    wait_cyc(24);
    rd(lro_pkg::OFS_INT_STAT, 32'h4, 32'h4, lro_pkg::RESP_OKAY);
    wait_cyc(1);
    chk("masked event", irq, 0);
    wr(lro_pkg::OFS_INT_MASK, 32'h4, lro_pkg::RESP_OKAY);
    wait_cyc(1);
    chk("unmasked event", irq, 1);
    wr(lro_pkg::OFS_INT_STAT, 32'h4, lro_pkg::RESP_OKAY);
    wait_cyc(1);
    chk("event cleared", irq, 0);
    ref_half = 10'h191;
    wait_cyc(17000);
    chk("lock within tolerance", loss_of_lock, 0);
    ref_half = 10'h193;
    for (int i = 0; i < 17000 && loss_of_lock !== 1'b1; i++)
      @(posedge clk);
    wait_cyc(1);
    chk("lock lost", loss_of_lock, 1);
    run = 1'b0;
    ref_half = 10'h190;
    measure(64, 1'b0);
    chk("reference clock edges", n_frc, 8);
    rd(lro_pkg::OFS_STATE, 32'h4, 32'h4, lro_pkg::RESP_OKAY);
    run = 1'b1;
    for (int i = 0; i < 17000 && loss_of_lock !== 1'b0; i++)
      @(posedge clk);
    wait_cyc(16);
    chk("lock regained", loss_of_lock, 0);
    rd(lro_pkg::OFS_STATE, 32'h0, 32'h4, lro_pkg::RESP_OKAY);
    @(posedge clk);
    host <= 1'b0;
    hw_dual <= 1'b0;
    hw_e3 <= 1'b1;
    do_reset();
    rd(lro_pkg::OFS_STATE, 32'h0, 32'h8, lro_pkg::RESP_OKAY);
    measure(64, 1'b0);
    chk("strapped shared clock", n_shr, 8);
    chk("strapped negative rail", n_neg, 0);
    chk("strapped positive rail", positive_rail_out, 1);
    chk("no runt clock pulse", frc_min >= 3, 1);
    end_of_test();
  end
endmodule
`default_nettype wire
